// File: logic/gxb_pin_routing.sv
// Pin routing top: register file, pin function muxes and the three crossbars.
`timescale 1ns/1ps
module gxb_pin_routing #(
	parameter int NGPIO = 97,
	parameter int NXSRC = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [gxb_pkg::GXB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [gxb_pkg::GXB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NGPIO-1:0] gpio_in,
	input wire logic [gxb_pkg::GXB_NPIN-1:0] gpio_out,
	input wire logic [gxb_pkg::GXB_NPIN-1:0] gpio_oe,
	input wire logic [gxb_pkg::GXB_NPIN*16-1:0] alt_out,
	input wire logic [gxb_pkg::GXB_NPIN*16-1:0] alt_oe,
	input wire logic [NXSRC-1:0] xbar_ext_src,
	output logic [gxb_pkg::GXB_NPIN-1:0] pin_out,
	output logic [gxb_pkg::GXB_NPIN-1:0] pin_oe,
	output logic [2:0] trip_zone,
	output logic [8:1] pwm_trip,
	output logic [5:1] external_interrupt_line,
	output logic external_conversion_trigger,
	output logic external_sync_input_one,
	output logic external_sync_input_two,
	output logic [5:0] capture_unit,
	output logic [7:0] output_crossbar_line,
	output logic usb_minus_line_en,
	output logic usb_plus_line_en,
	output logic [2:0] spi_hs_pins_ready
);
	import gxb_pkg::*;

	localparam int ISW = $clog2(NGPIO);
	localparam int NXB = GXB_N_SHARED_IN + NXSRC;
	localparam int XSW = $clog2(NXB);

	logic [31:0] amsel_r;
	logic [31:0] gmux_b_r;
	logic [31:0] mux_b_r;
	logic [31:0] gmux_c_r;
	logic [31:0] mux_c_r;
	logic [ISW-1:0] insel_r [GXB_N_INXBAR];
	logic [XSW-1:0] outsel_r [GXB_N_OUTXBAR];
	logic [XSW-1:0] pwmsel_r [GXB_N_PWMXBAR];
	logic [GXB_N_INXBAR-1:0] inx;
	logic [GXB_NPIN-1:0] rsvd;
	logic [GXB_NPIN-1:0] hs_sel;
	logic [7:0] pwmx;

	// Write channel: address and data are latched independently, in either order.
	logic aw_held_r;
	logic w_held_r;
	logic [GXB_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	wire logic aw_fire = s_axi_awvalid && s_axi_awready;
	wire logic w_fire = s_axi_wvalid && s_axi_wready;
	wire logic do_write = aw_held_r && w_held_r;

	wire logic [7:0] wa = awaddr_r & 8'hfc;
	wire logic w_in_xb = (wa >= GXB_OFF_INXBAR) && (wa < GXB_OFF_INXBAR + 8'(4*GXB_N_INXBAR));
	wire logic w_out_xb = (wa >= GXB_OFF_OUTXBAR) && (wa < GXB_OFF_OUTXBAR + 8'(4*GXB_N_OUTXBAR));
	wire logic w_pwm_xb = (wa >= GXB_OFF_PWMXBAR) && (wa < GXB_OFF_PWMXBAR + 8'(4*GXB_N_PWMXBAR));
	wire logic [3:0] w_in_k = 4'((wa - GXB_OFF_INXBAR) >> 2);
	wire logic [3:0] w_out_k = 4'((wa - GXB_OFF_OUTXBAR) >> 2);
	wire logic [3:0] w_pwm_k = 4'((wa - GXB_OFF_PWMXBAR) >> 2);
	wire logic w_plain = (wa == GXB_OFF_AMSEL_B) || (wa == GXB_OFF_GMUX_B_HI) ||
		(wa == GXB_OFF_MUX_B_HI) || (wa == GXB_OFF_GMUX_C_LO) || (wa == GXB_OFF_MUX_C_LO);
	wire logic w_ro = (wa == GXB_OFF_RSVD_STAT) || (wa == GXB_OFF_SPI_STAT);
	wire logic w_ok = w_plain || w_ro || w_in_xb || w_out_xb || w_pwm_xb;
	wire logic [31:0] wfull = gxb_apply_strb(32'h0000_0000, wdata_r, wstrb_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= GXB_RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_ok ? GXB_RESP_OKAY : GXB_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register storage; crossbar selects take the low byte lane.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amsel_r <= GXB_RST_REG;
			gmux_b_r <= GXB_RST_REG;
			mux_b_r <= GXB_RST_REG;
			gmux_c_r <= GXB_RST_REG;
			mux_c_r <= GXB_RST_REG;
			for (int k = 0; k < GXB_N_INXBAR; k++) begin
				insel_r[k] <= '0;
			end
			for (int k = 0; k < GXB_N_OUTXBAR; k++) begin
				outsel_r[k] <= '0;
				pwmsel_r[k] <= '0;
			end
		end else if (do_write) begin
			case (wa)
				GXB_OFF_AMSEL_B: amsel_r <= gxb_apply_strb(amsel_r, wdata_r, wstrb_r);
				GXB_OFF_GMUX_B_HI: gmux_b_r <= gxb_apply_strb(gmux_b_r, wdata_r, wstrb_r);
				GXB_OFF_MUX_B_HI: mux_b_r <= gxb_apply_strb(mux_b_r, wdata_r, wstrb_r);
				GXB_OFF_GMUX_C_LO: gmux_c_r <= gxb_apply_strb(gmux_c_r, wdata_r, wstrb_r);
				GXB_OFF_MUX_C_LO: mux_c_r <= gxb_apply_strb(mux_c_r, wdata_r, wstrb_r);
				default: begin
					if (w_in_xb && wstrb_r[0]) begin
						insel_r[w_in_k] <= wfull[ISW-1:0];
					end
					if (w_out_xb && wstrb_r[0]) begin
						outsel_r[w_out_k[2:0]] <= wfull[XSW-1:0];
					end
					if (w_pwm_xb && wstrb_r[0]) begin
						pwmsel_r[w_pwm_k[2:0]] <= wfull[XSW-1:0];
					end
				end
			endcase
		end
	end

	// Read channel: one read at a time, data registered one cycle after the address.
	wire logic [7:0] ra = s_axi_araddr & 8'hfc;
	wire logic r_in_xb = (ra >= GXB_OFF_INXBAR) && (ra < GXB_OFF_INXBAR + 8'(4*GXB_N_INXBAR));
	wire logic r_out_xb = (ra >= GXB_OFF_OUTXBAR) && (ra < GXB_OFF_OUTXBAR + 8'(4*GXB_N_OUTXBAR));
	wire logic r_pwm_xb = (ra >= GXB_OFF_PWMXBAR) && (ra < GXB_OFF_PWMXBAR + 8'(4*GXB_N_PWMXBAR));
	wire logic [3:0] r_in_k = 4'((ra - GXB_OFF_INXBAR) >> 2);
	wire logic [2:0] r_out_k = 3'((ra - GXB_OFF_OUTXBAR) >> 2);
	wire logic [2:0] r_pwm_k = 3'((ra - GXB_OFF_PWMXBAR) >> 2);
	logic [31:0] rd_val;
	logic rd_ok;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		case (ra)
			GXB_OFF_AMSEL_B: rd_val = amsel_r;
			GXB_OFF_GMUX_B_HI: rd_val = gmux_b_r;
			GXB_OFF_MUX_B_HI: rd_val = mux_b_r;
			GXB_OFF_GMUX_C_LO: rd_val = gmux_c_r;
			GXB_OFF_MUX_C_LO: rd_val = mux_c_r;
			GXB_OFF_RSVD_STAT: rd_val = rsvd;
			GXB_OFF_SPI_STAT: rd_val = {29'h0, spi_hs_pins_ready};
			default: begin
				if (r_in_xb) begin
					rd_val = 32'(insel_r[r_in_k]);
				end else if (r_out_xb) begin
					rd_val = 32'(outsel_r[r_out_k]);
				end else if (r_pwm_xb) begin
					rd_val = 32'(pwmsel_r[r_pwm_k]);
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= GXB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? GXB_RESP_OKAY : GXB_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Pin function muxes; pins 48..63 use the port B fields, 64..79 the port C fields.
	wire logic [63:0] gsel_all = {gmux_c_r, gmux_b_r};
	wire logic [63:0] fsel_all = {mux_c_r, mux_b_r};
	genvar p;
	generate
		for (p = 0; p < GXB_NPIN; p++) begin : g_pin
			logic [15:0] a_out;
			logic [15:0] a_oe;
			// The output crossbar line takes one alternate slot on each pin.
			always_comb begin
				a_out = alt_out[p*16 +: 16];
				a_oe = alt_oe[p*16 +: 16];
				a_out[GXB_IDX_OUTXBAR] = output_crossbar_line[p % GXB_N_OUTXBAR];
			end
			assign hs_sel[p] = (gxb_func_index(gsel_all[2*p +: 2], fsel_all[2*p +: 2]) ==
				GXB_IDX_SPI_HS);
			gxb_pin_func u_pin (
				.aclk(aclk),
				.aresetn(aresetn),
				.group_sel(gsel_all[2*p +: 2]),
				.func_sel(fsel_all[2*p +: 2]),
				.gpio_out(gpio_out[p]),
				.gpio_oe(gpio_oe[p]),
				.alt_out(a_out),
				.alt_oe(a_oe),
				.pin_out(pin_out[p]),
				.pin_oe(pin_oe[p]),
				.reserved(rsvd[p])
			);
		end
	endgenerate

	// Software reads these to confirm a port is on its high-speed pins before enabling it.
	assign spi_hs_pins_ready[0] = ((hs_sel & GXB_SPI_A_MASK) == GXB_SPI_A_MASK);
	assign spi_hs_pins_ready[1] = ((hs_sel & GXB_SPI_B_MASK) == GXB_SPI_B_MASK);
	assign spi_hs_pins_ready[2] = ((hs_sel & GXB_SPI_C_MASK) == GXB_SPI_C_MASK);

	assign usb_minus_line_en = amsel_r[GXB_USB_MINUS_BIT];
	assign usb_plus_line_en = amsel_r[GXB_USB_PLUS_BIT];

	// Input crossbar: each channel picks any GPIO input.
	genvar c;
	generate
		for (c = 0; c < GXB_N_INXBAR; c++) begin : g_inx
			gxb_sel_mux #(.N(NGPIO), .SW(ISW)) u_mux (
				.aclk(aclk),
				.aresetn(aresetn),
				.src(gpio_in),
				.sel(insel_r[c]),
				.y(inx[c])
			);
		end
	endgenerate

	assign trip_zone = inx[2:0];
	assign external_interrupt_line[1] = inx[3];
	assign external_interrupt_line[2] = inx[4];
	assign external_conversion_trigger = inx[4];
	assign external_sync_input_one = inx[4];
	assign external_interrupt_line[3] = inx[5];
	assign external_sync_input_two = inx[5];
	assign capture_unit = inx[11:6];
	assign external_interrupt_line[5:4] = inx[13:12];

	// Trip inputs 1-3 and 6 also see the input channels directly; the PWM crossbar is ORed in.
	always_comb begin
		pwm_trip = pwmx;
		pwm_trip[3:1] = pwmx[2:0] | inx[2:0];
		pwm_trip[6] = pwmx[5] | inx[5];
	end

	// Shared crossbar sources: input channels 1-6 first, then the other peripheral sources.
	wire logic [NXB-1:0] xsrc = {xbar_ext_src, inx[5:0]};
	genvar o;
	generate
		for (o = 0; o < GXB_N_OUTXBAR; o++) begin : g_xb
			gxb_sel_mux #(.N(NXB), .SW(XSW)) u_out (
				.aclk(aclk),
				.aresetn(aresetn),
				.src(xsrc),
				.sel(outsel_r[o]),
				.y(output_crossbar_line[o])
			);
			gxb_sel_mux #(.N(NXB), .SW(XSW)) u_pwm (
				.aclk(aclk),
				.aresetn(aresetn),
				.src(xsrc),
				.sel(pwmsel_r[o]),
				.y(pwmx[o])
			);
		end
	endgenerate
endmodule

// File: common/gxb_pkg.sv
// Shared constants, register map and helper functions for the pin routing block.
package gxb_pkg;

	localparam int GXB_ADDR_W = 8;
	localparam int GXB_DATA_W = 32;
	localparam int GXB_FIELD_W = 2;
	localparam int GXB_IDX_W = 4;

	// Register byte offsets.
	localparam logic [7:0] GXB_OFF_AMSEL_B = 8'h00;
	localparam logic [7:0] GXB_OFF_GMUX_B_HI = 8'h04;
	localparam logic [7:0] GXB_OFF_MUX_B_HI = 8'h08;
	localparam logic [7:0] GXB_OFF_GMUX_C_LO = 8'h0c;
	localparam logic [7:0] GXB_OFF_MUX_C_LO = 8'h10;
	localparam logic [7:0] GXB_OFF_RSVD_STAT = 8'h14;
	localparam logic [7:0] GXB_OFF_SPI_STAT = 8'h18;
	localparam logic [7:0] GXB_OFF_INXBAR = 8'h40;
	localparam logic [7:0] GXB_OFF_OUTXBAR = 8'h80;
	localparam logic [7:0] GXB_OFF_PWMXBAR = 8'ha0;

	localparam logic [31:0] GXB_RST_REG = 32'h0000_0000;
	localparam logic [1:0] GXB_RESP_OKAY = 2'h0;
	localparam logic [1:0] GXB_RESP_SLVERR = 2'h2;

	// Managed pins: port B high half (48..63) and port C low half (64..79).
	localparam int GXB_FIRST_PIN = 48;
	localparam int GXB_NPIN = 32;
	localparam int GXB_PINS_PER_REG = 16;

	// Function index encodings.
	localparam logic [3:0] GXB_IDX_SPI_HS = 4'hf;
	localparam logic [3:0] GXB_IDX_OUTXBAR = 4'h5;

	// Analog mode select bits giving the USB lines to pins 42 and 43.
	localparam int GXB_USB_MINUS_BIT = 10;
	localparam int GXB_USB_PLUS_BIT = 11;

	// High-speed SPI pin masks relative to pin 48.
	localparam logic [31:0] GXB_SPI_A_MASK = 32'h0000_3c00;
	localparam logic [31:0] GXB_SPI_B_MASK = 32'h0007_8000;
	localparam logic [31:0] GXB_SPI_C_MASK = 32'h01e0_0000;

	// Crossbar sizes.
	localparam int GXB_N_INXBAR = 14;
	localparam int GXB_N_OUTXBAR = 8;
	localparam int GXB_N_PWMXBAR = 8;
	localparam int GXB_N_SHARED_IN = 6;

	function automatic logic [3:0] gxb_func_index(input logic [1:0] grp, input logic [1:0] sel);
		gxb_func_index = {grp, sel};
	endfunction

	function automatic logic gxb_is_reserved(input logic [3:0] idx);
		gxb_is_reserved = (idx == 4'h9) || (idx == 4'ha) || (idx == 4'hb) ||
			(idx == 4'hd) || (idx == 4'he);
	endfunction

	function automatic logic [31:0] gxb_apply_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		gxb_apply_strb = res;
	endfunction

endpackage

// File: logic/gxb_pin_func.sv
// Function selector for one multiplexed pin.
`timescale 1ns/1ps
module gxb_pin_func (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [gxb_pkg::GXB_FIELD_W-1:0] group_sel,
	input wire logic [gxb_pkg::GXB_FIELD_W-1:0] func_sel,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	input wire logic [15:0] alt_out,
	input wire logic [15:0] alt_oe,
	output logic pin_out,
	output logic pin_oe,
	output logic reserved
);
	import gxb_pkg::*;

	wire logic [3:0] idx = gxb_func_index(group_sel, func_sel);
	wire logic is_rsvd = gxb_is_reserved(idx);
	wire logic is_gpio = (func_sel == 2'h0);
	// A reserved selection drives nothing, so a bad setting cannot fight the board.
	wire logic out_nxt = is_gpio ? gpio_out : (is_rsvd ? 1'b0 : alt_out[idx]);
	wire logic oe_nxt = is_gpio ? gpio_oe : (is_rsvd ? 1'b0 : alt_oe[idx]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			reserved <= 1'b0;
		end else begin
			pin_out <= out_nxt;
			pin_oe <= oe_nxt;
			reserved <= is_rsvd;
		end
	end
endmodule

// File: logic/gxb_sel_mux.sv
// Registered one-of-N selector used by every crossbar channel.
`timescale 1ns/1ps
module gxb_sel_mux #(
	parameter int N = 8,
	parameter int SW = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [N-1:0] src,
	input wire logic [SW-1:0] sel,
	output logic y
);
	// Selections beyond the last source give a constant low.
	wire logic in_range = (32'(sel) < N);
	wire logic y_nxt = in_range ? src[sel] : 1'b0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			y <= 1'b0;
		end else begin
			y <= y_nxt;
		end
	end
endmodule

// File: sim/gxb_routing_checker.sv
// Concurrent checks on the ports of the pin routing top.
`timescale 1ns/1ps
module gxb_routing_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] trip_zone,
	input wire logic [8:1] pwm_trip,
	input wire logic [5:1] external_interrupt_line,
	input wire logic external_conversion_trigger,
	input wire logic external_sync_input_one,
	input wire logic external_sync_input_two,
	input wire logic usb_minus_line_en,
	input wire logic usb_plus_line_en,
	input wire logic [2:0] spi_hs_pins_ready
);
	import gxb_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_trip_to_pwm: assert property ((trip_zone & ~pwm_trip[3:1]) == 3'h0)
		else $error("trip zone level missing on pwm trip");
	chk_sync_two_path: assert property (external_sync_input_two |->
		external_interrupt_line[3] && pwm_trip[6])
		else $error("channel six destinations disagree");
	chk_conv_sync_pair: assert property ((external_conversion_trigger ==
		external_sync_input_one) && (external_sync_input_one == external_interrupt_line[2]))
		else $error("channel five destinations disagree");
	chk_cfg_after_write: assert property (!$stable({usb_minus_line_en, usb_plus_line_en,
		spi_hs_pins_ready}) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("pin option changed without a register write");
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
		else $error("read data dropped before rready");
	chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after address");
	chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two cycles after address and data");
	chk_busy_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	cover property (usb_minus_line_en && usb_plus_line_en);
	cover property (spi_hs_pins_ready == 3'h7);
	cover property (s_axi_rvalid && s_axi_rresp == GXB_RESP_SLVERR);
endmodule
bind gxb_pin_routing gxb_routing_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.trip_zone, .pwm_trip, .external_interrupt_line, .external_conversion_trigger,
	.external_sync_input_one, .external_sync_input_two, .usb_minus_line_en,
	.usb_plus_line_en, .spi_hs_pins_ready);

// File: sim/gxb_periph_model.sv
// Peripheral side model: GPIO and alternate function drive for pins 48 to 79.
`timescale 1ns/1ps
module gxb_periph_model (
	output logic [gxb_pkg::GXB_NPIN-1:0] gpio_out,
	output logic [gxb_pkg::GXB_NPIN-1:0] gpio_oe,
	output logic [gxb_pkg::GXB_NPIN*16-1:0] alt_out,
	output logic [gxb_pkg::GXB_NPIN*16-1:0] alt_oe
);
	import gxb_pkg::*;
	// Slot patterns differ from the GPIO drive so that a wrong select shows at the pin.
	assign gpio_out = 32'h5a5a_a5a4;
	assign gpio_oe = 32'hffff_ffff;
	assign alt_out = {GXB_NPIN{16'hc6b3}};
	assign alt_oe = {GXB_NPIN{16'hdfbe}};
endmodule

// File: sim/test_gxb_pin_routing.sv
// Self-checking testbench for the pin routing block.
`timescale 1ns/1ps
module test_gxb_pin_routing;
	import gxb_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, xbar_ext_src, output_crossbar_line;
	logic [31:0] s_axi_wdata, s_axi_rdata, gpio_out, gpio_oe, pin_out, pin_oe;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [96:0] gpio_in;
	logic [511:0] alt_out, alt_oe;
	logic [2:0] trip_zone, spi_hs_pins_ready;
	logic [8:1] pwm_trip;
	logic [5:1] external_interrupt_line;
	logic external_conversion_trigger, external_sync_input_one, external_sync_input_two;
	logic usb_minus_line_en, usb_plus_line_en;
	logic [5:0] capture_unit;
	int n_mismatch = 0;
	int checks_done = 0;
	gxb_pin_routing dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_in, .gpio_out, .gpio_oe, .alt_out,
		.alt_oe, .xbar_ext_src, .pin_out, .pin_oe, .trip_zone, .pwm_trip,
		.external_interrupt_line, .external_conversion_trigger, .external_sync_input_one,
		.external_sync_input_two, .capture_unit, .output_crossbar_line, .usb_minus_line_en,
		.usb_plus_line_en, .spi_hs_pins_ready);
	gxb_periph_model periph_u (.gpio_out, .gpio_oe, .alt_out, .alt_oe);
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge aclk);
	endtask
	// The response ready is raised only after valid is seen, so the slave must hold it.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, bw, bd;
		logic [1:0] r;
		bd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 40 && !bd; n++) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bw = s_axi_bvalid;
			bd = bw && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			s_axi_bready <= bw && !bd;
		end
		if (!bd) begin
			n_mismatch++;
			complete_run();
		end
		chk("write resp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ah, rw, rd;
		logic [31:0] d;
		logic [1:0] r;
		rd = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 40 && !rd; n++) begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			rw = s_axi_rvalid;
			rd = rw && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
			s_axi_rready <= rw && !rd;
		end
		if (!rd) begin
			n_mismatch++;
			complete_run();
		end
		chk("read data", e, d);
		chk("read resp", {30'h0, er}, {30'h0, r});
	endtask
	// Destination pattern of one input channel, packed as in the compare below.
	function automatic logic [31:0] dst(input int k);
		case (k)
			1, 2, 3: dst = 32'h1 << (k - 1);
			4: dst = 32'h8;
			5: dst = 32'h310;
			6: dst = 32'h420;
			13: dst = 32'h40;
			14: dst = 32'h80;
			default: dst = 32'h1 << (k + 4);
		endcase
	endfunction
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		logic rsv, eo, ep;
		logic [31:0] ex, got;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		gpio_in = 97'h0;
		xbar_ext_src = 8'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'h0, GXB_RESP_OKAY);
		rchk(8'h20, 32'h0, GXB_RESP_SLVERR);
		axw(8'h20, 32'hffff_ffff, GXB_RESP_SLVERR);
		axw(GXB_OFF_RSVD_STAT, 32'hffff_ffff, GXB_RESP_OKAY);
		rchk(GXB_OFF_RSVD_STAT, 32'h0, GXB_RESP_OKAY);
		for (int i = 1; i < 4; i++) begin
			axw(GXB_OFF_AMSEL_B, 32'(i) << 10, GXB_RESP_OKAY);
			settle(2);
			chk("usb lines", 32'(i), {30'h0, usb_plus_line_en, usb_minus_line_en});
		end
		rchk(GXB_OFF_AMSEL_B, 32'h0000_0c00, GXB_RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			axw(GXB_OFF_GMUX_B_HI, {30'h0, i[3:2]}, GXB_RESP_OKAY);
			axw(GXB_OFF_MUX_B_HI, {30'h0, i[1:0]}, GXB_RESP_OKAY);
			settle(2);
			rsv = i inside {9, 10, 11, 13, 14};
			// Slot 5 carries output crossbar line 0, which follows the idle GPIO 0 input here.
			ep = (rsv || i == 5) ? 1'b0 : (i[1:0] == 2'h0) ? gpio_out[0] : alt_out[i];
			eo = rsv ? 1'b0 : (i[1:0] == 2'h0) ? gpio_oe[0] : alt_oe[i];
			chk("pin 48 drive", {31'h0, ep}, {31'h0, pin_out[0]});
			chk("pin 48 enable", {31'h0, eo}, {31'h0, pin_oe[0]});
			rchk(GXB_OFF_RSVD_STAT, {31'h0, rsv}, GXB_RESP_OKAY);
		end
		axw(GXB_OFF_GMUX_B_HI, 32'hcff0_0000, GXB_RESP_OKAY);
		axw(GXB_OFF_MUX_B_HI, 32'hcff0_0000, GXB_RESP_OKAY);
		settle(2);
		chk("spi pin option", 32'h1, {29'h0, spi_hs_pins_ready});
		chk("pin 58 drive", {31'h0, alt_out[175]}, {31'h0, pin_out[10]});
		axw(GXB_OFF_GMUX_C_LO, 32'h0003_fc3f, GXB_RESP_OKAY);
		axw(GXB_OFF_MUX_C_LO, 32'h0003_fc3f, GXB_RESP_OKAY);
		settle(2);
		chk("spi pin option", 32'h7, {29'h0, spi_hs_pins_ready});
		rchk(GXB_OFF_GMUX_C_LO, 32'h0003_fc3f, GXB_RESP_OKAY);
		axw(GXB_OFF_MUX_C_LO, 32'h0003_fc3e, GXB_RESP_OKAY);
		settle(2);
		chk("spi pin option", 32'h5, {29'h0, spi_hs_pins_ready});
		chk("pin 64 enable", 32'h0, {31'h0, pin_oe[16]});
		rchk(GXB_OFF_RSVD_STAT, 32'h0001_0000, GXB_RESP_OKAY);
		for (int j = 0; j < 8; j++) begin
			axw(GXB_OFF_OUTXBAR + 8'(4 * j), 32'(j), GXB_RESP_OKAY);
			axw(GXB_OFF_PWMXBAR + 8'(4 * j), 32'(j), GXB_RESP_OKAY);
		end
		for (int k = 1; k < 15; k++) begin
			axw(GXB_OFF_INXBAR + 8'(4 * k - 4), 32'(6 * k + 12), GXB_RESP_OKAY);
		end
		for (int k = 1; k < 15; k++) begin
			@(posedge aclk);
			gpio_in <= 97'h1 << (6 * k + 12);
			settle(3);
			ex = (k < 7) ? 32'h1 << (k - 1) : 32'h0;
			got = {15'h0, capture_unit, external_sync_input_two, external_sync_input_one,
				external_conversion_trigger, external_interrupt_line, trip_zone};
			chk("channel outputs", dst(k), got);
			chk("pwm trips", ex, {24'h0, pwm_trip});
			chk("output xbar", ex, {24'h0, output_crossbar_line});
		end
		@(posedge aclk);
		gpio_in <= 97'h0;
		xbar_ext_src <= 8'h03;
		settle(3);
		chk("pwm trips", 32'hc0, {24'h0, pwm_trip});
		chk("output xbar", 32'hc0, {24'h0, output_crossbar_line});
		complete_run();
	end
endmodule
